// file: eip_bus_host.sv
`timescale 1ns/10ps
`default_nettype none
module eip_bus_host
   import eip_pkg::*;
(
   input  wire logic              i_clk,
   input  wire logic              i_rst_n,
   input  wire logic              i_req,
   input  wire eip_cmd_t          i_cmd,
   input  wire logic [SEL_W-1:0]  i_sel,
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic [BYTE_W-1:0] i_wdata,
   input  wire logic [CNT_W-1:0]  i_count,
   output logic                   o_ready,
   output logic [BYTE_W-1:0]      o_rdata,
   output logic                   o_rvalid,
   output logic                   o_done,
   output logic                   o_nack,
   eip_link_if.host               link
);

   typedef enum logic [2:0] {H_IDLE, H_START, H_TX, H_RX, H_STOP} eip_hstate_t;
   typedef enum logic [2:0] {S_CTRLW, S_AHI, S_ALO, S_WDATA, S_CTRLR, S_READ} eip_stage_t;

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   eip_hstate_t       state_q, state_d;
   eip_stage_t        stage_q, stage_d;
   eip_cmd_t          cmd_q, cmd_d;
   logic [SEL_W-1:0]  sel_q, sel_d;
   logic [ADDR_W-1:0] addr_q, addr_d;
   logic [BYTE_W-1:0] wdata_q, wdata_d;
   logic [CNT_W-1:0]  count_q, count_d;
   logic [TICK_W-1:0] tick_q, tick_d;
   logic [1:0]        qtr_q, qtr_d;
   logic [3:0]        bit_q, bit_d;
   logic [BYTE_W-1:0] shift_q, shift_d;
   logic              ackbit_q, ackbit_d;
   logic              fail_q, fail_d;
   logic [1:0]        sync_q, sync_d;
   logic              scl_q, scl_d;
   logic              lvl_q, lvl_d;
   logic              oe_q, oe_d;
   logic              ready_q, ready_d;
   logic [BYTE_W-1:0] rdata_q, rdata_d;
   logic              rvalid_q, rvalid_d;
   logic              done_q, done_d;
   logic              nack_q, nack_d;

   wire logic qend    = (tick_q == QTR_LAST);
   wire logic sym_end = qend && (qtr_q == Q_LAST);
   wire logic sample  = qend && (qtr_q == Q_SAMPLE);
   wire logic sda_now = sync_q[1];

   always_comb
   begin
      state_d  = state_q;
      stage_d  = stage_q;
      cmd_d    = cmd_q;
      sel_d    = sel_q;
      addr_d   = addr_q;
      wdata_d  = wdata_q;
      count_d  = count_q;
      tick_d   = '0;
      qtr_d    = qtr_q;
      bit_d    = bit_q;
      shift_d  = shift_q;
      ackbit_d = ackbit_q;
      fail_d   = fail_q;
      ready_d  = ready_q;
      rdata_d  = rdata_q;
      rvalid_d = 1'b0;
      done_d   = 1'b0;
      nack_d   = 1'b0;
      sync_d   = {sync_q[0], link.sda};
      if (state_q != H_IDLE)
      begin
         tick_d = qend ? '0 : tick_q + 4'h1;
         if (qend)
            qtr_d = qtr_q + 2'h1;
      end
      case (state_q)
         H_IDLE:
            if (i_req)
            begin
               cmd_d   = i_cmd;
               sel_d   = i_sel;
               addr_d  = i_addr;
               wdata_d = i_wdata;
               count_d = (i_count == '0) ? ONE_BYTE : i_count;
               fail_d  = 1'b0;
               ready_d = 1'b0;
               stage_d = (i_cmd == EIP_CMD_CUR_READ) ? S_CTRLR : S_CTRLW;
               state_d = H_START;
            end
         H_START:
            if (sym_end)
            begin
               state_d = H_TX;
               bit_d   = '0;
               shift_d = {ctrl_prefix(sel_q), stage_q == S_CTRLR};
            end
         H_TX:
         begin
            if (sample && bit_q == ACK_SLOT)
               ackbit_d = sda_now;
            if (sym_end)
            begin
               if (bit_q != ACK_SLOT)
               begin
                  bit_d   = bit_q + 4'h1;
                  shift_d = {shift_q[BYTE_W-2:0], 1'b0};
               end
               else if (ackbit_q)
               begin
                  if (cmd_q == EIP_CMD_POLL)
                     state_d = H_START;
                  else
                  begin
                     fail_d  = 1'b1;
                     state_d = H_STOP;
                  end
               end
               else
               begin
                  bit_d = '0;
                  case (stage_q)
                     S_CTRLW:
                        if (cmd_q == EIP_CMD_POLL)
                           state_d = H_STOP;
                        else
                        begin
                           stage_d = S_AHI;
                           shift_d = BYTE_W'(addr_q[ADDR_W-1:BYTE_W]);
                        end
                     S_AHI:
                     begin
                        stage_d = S_ALO;
                        shift_d = addr_q[BYTE_W-1:0];
                     end
                     S_ALO:
                        if (cmd_q == EIP_CMD_WRITE)
                        begin
                           stage_d = S_WDATA;
                           shift_d = wdata_q;
                        end
                        else
                        begin
                           stage_d = S_CTRLR;
                           state_d = H_START;
                        end
                     S_CTRLR:
                     begin
                        stage_d  = S_READ;
                        state_d  = H_RX;
                        ackbit_d = (count_q == ONE_BYTE);
                     end
                     default:
                        state_d = H_STOP;
                  endcase
               end
            end
         end
         H_RX:
         begin
            if (sample && bit_q != ACK_SLOT)
               shift_d = {shift_q[BYTE_W-2:0], sda_now};
            if (sym_end)
            begin
               if (bit_q == LAST_BIT)
               begin
                  rdata_d  = shift_q;
                  rvalid_d = 1'b1;
               end
               if (bit_q != ACK_SLOT)
                  bit_d = bit_q + 4'h1;
               else
               begin
                  bit_d   = '0;
                  count_d = count_q - ONE_BYTE;
                  if (count_q == ONE_BYTE)
                     state_d = H_STOP;
                  else
                     ackbit_d = (count_q == TWO_BYTES);
               end
            end
         end
         H_STOP:
            if (sym_end)
            begin
               state_d = H_IDLE;
               done_d  = 1'b1;
               nack_d  = fail_q;
               ready_d = 1'b1;
            end
         default:
            state_d = H_IDLE;
      endcase
      // Levels per quarter; clock only moves while data is steady
      case (state_q)
         H_START:
         begin
            scl_d = (qtr_q == 2'h1) || (qtr_q == Q_SAMPLE);
            lvl_d = (qtr_q < Q_SAMPLE);
         end
         H_STOP:
         begin
            scl_d = (qtr_q != 2'h0);
            lvl_d = (qtr_q >= Q_SAMPLE);
         end
         H_TX:
         begin
            scl_d = (qtr_q == 2'h1) || (qtr_q == Q_SAMPLE);
            lvl_d = (bit_q == ACK_SLOT) ? 1'b1 : shift_q[BYTE_W-1];
         end
         H_RX:
         begin
            scl_d = (qtr_q == 2'h1) || (qtr_q == Q_SAMPLE);
            lvl_d = (bit_q == ACK_SLOT) ? ackbit_q : 1'b1;
         end
         default:
         begin
            scl_d = 1'b1;
            lvl_d = 1'b1;
         end
      endcase
      oe_d = ~lvl_d;
   end

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         state_q  <= H_IDLE;
         stage_q  <= S_CTRLW;
         cmd_q    <= EIP_CMD_WRITE;
         sel_q    <= '0;
         addr_q   <= '0;
         wdata_q  <= '0;
         count_q  <= '0;
         tick_q   <= '0;
         qtr_q    <= '0;
         bit_q    <= '0;
         shift_q  <= '0;
         ackbit_q <= 1'b1;
         fail_q   <= 1'b0;
         sync_q   <= '1;
         scl_q    <= 1'b1;
         lvl_q    <= 1'b1;
         oe_q     <= 1'b0;
         ready_q  <= 1'b1;
         rdata_q  <= '0;
         rvalid_q <= 1'b0;
         done_q   <= 1'b0;
         nack_q   <= 1'b0;
      end
      else
      begin
         state_q  <= state_d;
         stage_q  <= stage_d;
         cmd_q    <= cmd_d;
         sel_q    <= sel_d;
         addr_q   <= addr_d;
         wdata_q  <= wdata_d;
         count_q  <= count_d;
         tick_q   <= tick_d;
         qtr_q    <= qtr_d;
         bit_q    <= bit_d;
         shift_q  <= shift_d;
         ackbit_q <= ackbit_d;
         fail_q   <= fail_d;
         sync_q   <= sync_d;
         scl_q    <= scl_d;
         lvl_q    <= lvl_d;
         oe_q     <= oe_d;
         ready_q  <= ready_d;
         rdata_q  <= rdata_d;
         rvalid_q <= rvalid_d;
         done_q   <= done_d;
         nack_q   <= nack_d;
      end
   end

   assign link.scl         = scl_q;
   assign link.host_sda_o  = lvl_q;
   assign link.host_sda_oe = oe_q;
   assign o_ready          = ready_q;
   assign o_rdata          = rdata_q;
   assign o_rvalid         = rvalid_q;
   assign o_done           = done_q;
   assign o_nack           = nack_q;

endmodule
`default_nettype wire

// file: eip_pkg.sv
`default_nettype none
package eip_pkg;

   // ----------------------------------------------------------------
   // Widths and codes
   // ----------------------------------------------------------------
   localparam int       BYTE_W    = 8;
   localparam int       ADDR_W    = 12;
   localparam int       ADDR_HI_W = ADDR_W - BYTE_W;
   localparam int       SEL_W     = 3;
   localparam int       PAGE_W    = 5;
   localparam int       MEM_WORDS = 4096;
   localparam int       CNT_W     = 8;
   localparam logic [3:0] CTRL_CODE = 4'hA;
   localparam logic [3:0] LAST_BIT  = 4'h7;
   localparam logic [3:0] ACK_SLOT  = 4'h8;
   localparam logic [CNT_W-1:0] ONE_BYTE  = 8'h01;
   localparam logic [CNT_W-1:0] TWO_BYTES = 8'h02;

   // ----------------------------------------------------------------
   // Host bit timing
   // ----------------------------------------------------------------
   localparam int       CLK_PERIOD_NS = 50;
   localparam int       SCL_QTR_NS    = 500;
   localparam int       SCL_QTR_CYC   = (SCL_QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int       TICK_W        = 4;
   localparam logic [TICK_W-1:0] QTR_LAST = TICK_W'(SCL_QTR_CYC - 1);
   localparam logic [1:0] Q_SAMPLE = 2'h2;
   localparam logic [1:0] Q_LAST   = 2'h3;

   // ----------------------------------------------------------------
   // Host commands
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      EIP_CMD_WRITE,
      EIP_CMD_CUR_READ,
      EIP_CMD_RAND_READ,
      EIP_CMD_POLL
   } eip_cmd_t;

   function automatic logic [BYTE_W-2:0] ctrl_prefix(input logic [SEL_W-1:0] sel);
      ctrl_prefix = {CTRL_CODE, sel};
   endfunction

   function automatic logic [ADDR_W-1:0] addr_inc(input logic [ADDR_W-1:0] a);
      addr_inc = a + 12'h001;
   endfunction

endpackage
`default_nettype wire

// file: eip_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface eip_link_if;
   logic scl;
   logic sda;
   logic host_sda_o;
   logic host_sda_oe;
   logic dev_sda_o;
   logic dev_sda_oe;

   // Wired-AND with pull-up
   assign sda = (host_sda_oe ? host_sda_o : 1'b1) & (dev_sda_oe ? dev_sda_o : 1'b1);

   modport host   (output scl, output host_sda_o, output host_sda_oe, input sda);
   modport device (input scl, input sda, output dev_sda_o, output dev_sda_oe);
endinterface
`default_nettype wire

// file: eip_eeprom_dev.sv
`timescale 1ns/10ps
`default_nettype none
module eip_eeprom_dev
   import eip_pkg::*;
#(
   parameter int unsigned P_BUSY_CYCLES = 10000
)
(
   input  wire logic  i_link_clk,
   input  wire logic  i_rst_n,
   input  wire logic  i_select_bit_high,
   input  wire logic  i_select_bit_mid,
   input  wire logic  i_select_bit_low,
   output logic       o_busy,
   eip_link_if.device link
);

   typedef enum logic [2:0] {
      D_IDLE,
      D_CTRL,
      D_ADDR_HI,
      D_ADDR_LO,
      D_WDATA,
      D_READ,
      D_IGNORE
   } eip_dstate_t;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [1:0]       scl_sync_q, scl_sync_d;
   logic [1:0]       sda_sync_q, sda_sync_d;
   logic [SEL_W-1:0] sel_m_q, sel_m_d;
   logic [SEL_W-1:0] sel_q, sel_d;
   logic             scl_p_q, scl_p_d;
   logic             sda_p_q, sda_p_d;

   always_comb
   begin
      scl_sync_d = {scl_sync_q[0], link.scl};
      sda_sync_d = {sda_sync_q[0], link.sda};
      sel_m_d    = {i_select_bit_high, i_select_bit_mid, i_select_bit_low};
      sel_d      = sel_m_q;
      scl_p_d    = scl_sync_q[1];
      sda_p_d    = sda_sync_q[1];
   end

   always_ff @(posedge i_link_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         scl_sync_q <= '1;
         sda_sync_q <= '1;
         sel_m_q    <= '0;
         sel_q      <= '0;
         scl_p_q    <= 1'b1;
         sda_p_q    <= 1'b1;
      end
      else
      begin
         scl_sync_q <= scl_sync_d;
         sda_sync_q <= sda_sync_d;
         sel_m_q    <= sel_m_d;
         sel_q      <= sel_d;
         scl_p_q    <= scl_p_d;
         sda_p_q    <= sda_p_d;
      end
   end

   wire logic scl_now = scl_sync_q[1];
   wire logic sda_now = sda_sync_q[1];
   wire logic start_c = scl_now & scl_p_q & sda_p_q & ~sda_now;
   wire logic stop_c  = scl_now & scl_p_q & ~sda_p_q & sda_now;
   wire logic rise_c  = scl_now & ~scl_p_q;
   wire logic fall_c  = ~scl_now & scl_p_q;

   // ----------------------------------------------------------------
   // Array
   // ----------------------------------------------------------------
   // No reset on the array; read before write gives unknown data
   logic [BYTE_W-1:0] mem_q [MEM_WORDS];
   logic              wr_en;

   // ----------------------------------------------------------------
   // Bus engine
   // ----------------------------------------------------------------
   eip_dstate_t       state_q, state_d;
   logic [3:0]        cnt_q, cnt_d;
   logic [BYTE_W-1:0] shift_q, shift_d;
   logic [BYTE_W-1:0] tx_q, tx_d;
   logic [ADDR_W-1:0] ptr_q, ptr_d;
   logic [ADDR_HI_W-1:0] ahi_q, ahi_d;
   logic              rw_q, rw_d;
   logic              acked_q, acked_d;
   logic              low_q, low_d;
   logic              lvl_q, lvl_d;
   logic              pend_q, pend_d;
   logic [31:0]       busy_cnt_q, busy_cnt_d;
   logic              busy_q, busy_d;
   logic              load_c;

   always_comb
   begin
      state_d    = state_q;
      cnt_d      = cnt_q;
      shift_d    = shift_q;
      tx_d       = tx_q;
      ptr_d      = ptr_q;
      ahi_d      = ahi_q;
      rw_d       = rw_q;
      acked_d    = acked_q;
      low_d      = low_q;
      pend_d     = pend_q;
      wr_en      = 1'b0;
      load_c     = 1'b0;
      busy_cnt_d = (busy_cnt_q == '0) ? '0 : busy_cnt_q - 32'h1;
      if (start_c)
      begin
         state_d = D_CTRL;
         // Parked at all ones: the clock fall closing a start is no bit
         cnt_d   = '1;
         low_d   = 1'b0;
         pend_d  = 1'b0;
      end
      else if (stop_c)
      begin
         state_d = D_IDLE;
         cnt_d   = '0;
         low_d   = 1'b0;
         pend_d  = 1'b0;
         if (pend_q)
            busy_cnt_d = P_BUSY_CYCLES;
      end
      else
      begin
         case (state_q)
            D_IDLE, D_IGNORE:
               cnt_d = '0;
            D_READ:
            begin
               if (rise_c && cnt_q == ACK_SLOT)
                  acked_d = ~sda_now;
               if (fall_c)
               begin
                  if (cnt_q < LAST_BIT)
                  begin
                     cnt_d = cnt_q + 4'h1;
                     tx_d  = {tx_q[BYTE_W-2:0], 1'b0};
                     low_d = ~tx_q[BYTE_W-2];
                  end
                  else if (cnt_q == LAST_BIT)
                  begin
                     cnt_d = ACK_SLOT;
                     low_d = 1'b0;
                  end
                  else if (acked_q)
                     load_c = 1'b1;
                  else
                     state_d = D_IGNORE;
               end
            end
            default:
            begin
               if (rise_c && cnt_q < ACK_SLOT)
                  shift_d = {shift_q[BYTE_W-2:0], sda_now};
               if (fall_c)
               begin
                  if ((cnt_q < LAST_BIT) || (cnt_q == '1))
                     cnt_d = cnt_q + 4'h1;
                  else if (cnt_q == LAST_BIT)
                  begin
                     cnt_d = ACK_SLOT;
                     low_d = 1'b1;
                     case (state_q)
                        D_CTRL:
                        begin
                           if (shift_q[BYTE_W-1:1] != ctrl_prefix(sel_q) || busy_q)
                           begin
                              low_d   = 1'b0;
                              state_d = D_IGNORE;
                           end
                           else
                              rw_d = shift_q[0];
                        end
                        D_ADDR_HI:
                           ahi_d = shift_q[ADDR_HI_W-1:0];
                        D_ADDR_LO:
                           ptr_d = {ahi_q, shift_q};
                        default:
                        begin
                           wr_en  = 1'b1;
                           ptr_d  = {ptr_q[ADDR_W-1:PAGE_W], ptr_q[PAGE_W-1:0] + 5'h01};
                           pend_d = 1'b1;
                        end
                     endcase
                  end
                  else
                  begin
                     cnt_d = '0;
                     low_d = 1'b0;
                     case (state_q)
                        D_CTRL:
                           if (rw_q)
                              load_c = 1'b1;
                           else
                              state_d = D_ADDR_HI;
                        D_ADDR_HI:
                           state_d = D_ADDR_LO;
                        default:
                           state_d = D_WDATA;
                     endcase
                  end
               end
            end
         endcase
      end
      if (load_c)
      begin
         state_d = D_READ;
         cnt_d   = '0;
         tx_d    = mem_q[ptr_q];
         low_d   = ~mem_q[ptr_q][BYTE_W-1];
         ptr_d   = addr_inc(ptr_q);
      end
      lvl_d  = ~low_d;
      busy_d = (busy_cnt_d != '0);
   end

   always_ff @(posedge i_link_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         state_q    <= D_IDLE;
         cnt_q      <= '0;
         shift_q    <= '0;
         tx_q       <= '0;
         ptr_q      <= '0;
         ahi_q      <= '0;
         rw_q       <= 1'b0;
         acked_q    <= 1'b0;
         low_q      <= 1'b0;
         lvl_q      <= 1'b1;
         pend_q     <= 1'b0;
         busy_cnt_q <= '0;
         busy_q     <= 1'b0;
      end
      else
      begin
         state_q    <= state_d;
         cnt_q      <= cnt_d;
         shift_q    <= shift_d;
         tx_q       <= tx_d;
         ptr_q      <= ptr_d;
         ahi_q      <= ahi_d;
         rw_q       <= rw_d;
         acked_q    <= acked_d;
         low_q      <= low_d;
         lvl_q      <= lvl_d;
         pend_q     <= pend_d;
         busy_cnt_q <= busy_cnt_d;
         busy_q     <= busy_d;
      end
   end

   // Written as received; no deferred page buffer
   always_ff @(posedge i_link_clk)
   begin
      if (wr_en)
         mem_q[ptr_q] <= shift_q;
   end

   assign link.dev_sda_o  = lvl_q;
   assign link.dev_sda_oe = low_q;
   assign o_busy          = busy_q;

endmodule
`default_nettype wire

// file: eip_link_sva.sv
`timescale 1ns/10ps
`default_nettype none
module eip_link_sva #(
   parameter int unsigned P_BUSY_CYCLES = 10000
)
(
   input wire logic i_link_clk,
   input wire logic i_rst_n,
   input wire logic scl,
   input wire logic sda,
   input wire logic dev_sda_o,
   input wire logic dev_sda_oe,
   input wire logic o_busy
);
   // ---------------------------------------------
   // Helper counters, too long for a repetition
   // ---------------------------------------------
   int unsigned busy_q;
   int unsigned age_q;
   always_ff @(posedge i_link_clk or negedge i_rst_n)
      if (!i_rst_n)
      begin
         busy_q <= 0;
         age_q  <= 99;
      end
      else
      begin
         busy_q <= o_busy ? busy_q + 1 : 0;
         age_q  <= (scl && sda && !$past(sda)) ? 0 : (age_q < 99 ? age_q + 1 : 99);
      end
   // ---------------------------------------------
   // Link checks
   // ---------------------------------------------
   default clocking cb @(posedge i_link_clk);
   endclocking
   default disable iff (!i_rst_n);
   a_ack_low_only: assert property (dev_sda_oe |-> !dev_sda_o)
      else $error("device enable high with data high");
   a_busy_silent: assert property (o_busy |-> !dev_sda_oe)
      else $error("device drove line while busy");
   a_busy_length: assert property ($fell(o_busy) |-> busy_q + 2 >= P_BUSY_CYCLES && busy_q <= P_BUSY_CYCLES + 2)
      else $error("busy time wrong");
   a_busy_after_stop: assert property ($rose(o_busy) |-> age_q <= 10)
      else $error("busy began away from a stop");
   a_bit_held: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
      else $error("device changed data while clock high");
   a_stop_released: assert property (scl && $rose(sda) |=> !dev_sda_oe [*8])
      else $error("device drove after stop");
   a_start_released: assert property (scl && $fell(sda) |=> !dev_sda_oe [*8])
      else $error("device drove after start");
   a_ack_held: assert property ($rose(dev_sda_oe) |=> dev_sda_oe [*8])
      else $error("device drive too short");
endmodule
`default_nettype wire

// file: testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import eip_pkg::*;
   localparam int unsigned LP_BUSY = 2000;
   logic              i_clk = 1'b0;
   logic              lclk = 1'b0;
   logic              rst_n = 1'b0;
   logic              lrst_n = 1'b0;
   logic              req = 1'b0;
   eip_cmd_t          cmd = EIP_CMD_WRITE;
   logic [SEL_W-1:0]  sel = 3'h0;
   logic [SEL_W-1:0]  pins = 3'h0;
   logic [ADDR_W-1:0] addr = 12'h000;
   logic [BYTE_W-1:0] wdata = 8'h00;
   logic [CNT_W-1:0]  cnt = 8'h01;
   logic [BYTE_W-1:0] rdata;
   logic              rdy, rv, done, nack, busy, got_nack;
   logic [BYTE_W-1:0] mem [MEM_WORDS];
   logic [BYTE_W-1:0] got [$];
   int                miscompares = 0;
   int                n_compared = 0;
   int                seed = 32'h1f18;
   initial forever #25 i_clk = ~i_clk;
   initial
   begin
      #3.7;
      forever #6 lclk = ~lclk;
   end
   // Device reset released on its own clock
   always @(posedge lclk or negedge rst_n) lrst_n <= rst_n;
   eip_link_if link ();
   eip_eeprom_dev #(.P_BUSY_CYCLES(LP_BUSY)) u_eip_eeprom_dev (.i_link_clk(lclk),
      .i_rst_n(lrst_n), .i_select_bit_high(pins[2]), .i_select_bit_mid(pins[1]),
      .i_select_bit_low(pins[0]), .o_busy(busy), .link(link.device));
   eip_bus_host u_eip_bus_host (.i_clk(i_clk), .i_rst_n(rst_n), .i_req(req), .i_cmd(cmd),
      .i_sel(sel), .i_addr(addr), .i_wdata(wdata), .i_count(cnt), .o_ready(rdy),
      .o_rdata(rdata), .o_rvalid(rv), .o_done(done), .o_nack(nack), .link(link.host));
   eip_link_sva #(.P_BUSY_CYCLES(LP_BUSY)) u_eip_link_sva (.i_link_clk(lclk),
      .i_rst_n(lrst_n), .scl(link.scl), .sda(link.sda), .dev_sda_o(link.dev_sda_o),
      .dev_sda_oe(link.dev_sda_oe), .o_busy(busy));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      $display("compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic run(input eip_cmd_t c, input logic [11:0] a, input logic [7:0] d,
                      input logic [7:0] n);
      int k;
      k = 0;
      @(posedge i_clk);
      cmd <= c;
      addr <= a;
      wdata <= d;
      cnt <= n;
      req <= 1'b1;
      @(posedge i_clk);
      req <= 1'b0;
      got = {};
      while (k < 40000)
      begin
         @(posedge i_clk);
         #1;
         k++;
         if (rv === 1'b1) got.push_back(rdata);
         if (done === 1'b1) break;
      end
      got_nack = nack;
      if (k >= 40000)
      begin
         miscompares++;
         wrap_up();
      end
   endtask
   // Write then wait out the busy time by polling
   task automatic wr(input logic [11:0] a);
      mem[a] = $random(seed);
      run(EIP_CMD_WRITE, a, mem[a], 8'h01);
      run(EIP_CMD_POLL, a, 8'h00, 8'h01);
      check(busy, 1'b0);
      check(rdy, 1'b1);
   endtask
   task automatic rd(input eip_cmd_t c, input logic [11:0] a, input logic [11:0] s,
                     input logic [7:0] n);
      logic [11:0] p;
      run(c, a, 8'h00, n);
      check(got.size(), n);
      for (int i = 0; i < n && i < got.size(); i++)
      begin
         p = s + i[11:0];
         check(got[i], mem[p]);
      end
   endtask
   initial
   begin
      logic [11:0] a;
      pins = SEL_W'($random(seed));
      sel = pins;
      repeat (3) @(posedge i_clk);
      rst_n <= 1'b1;
      a = ($random(seed) & 12'hFE0) | 12'h005;
      mem[a] = $random(seed);
      run(EIP_CMD_WRITE, a, mem[a], 8'h01);
      check(got_nack, 1'b0);
      run(EIP_CMD_CUR_READ, a, 8'h00, 8'h01);
      check(got_nack, 1'b1);
      run(EIP_CMD_POLL, a, 8'h00, 8'h01);
      check(busy, 1'b0);
      wr(a + 12'h001);
      rd(EIP_CMD_RAND_READ, a, a, 8'h01);
      rd(EIP_CMD_CUR_READ, a, a + 12'h001, 8'h01);
      $display("test single reads done");
      wr(12'hFFE);
      wr(12'hFFF);
      wr(12'h000);
      wr(12'h001);
      rd(EIP_CMD_RAND_READ, 12'hFFE, 12'hFFE, 8'h03);
      $display("test wrap read done");
      for (int k = 1; k < 8; k++)
      begin
         sel <= pins ^ k[2:0];
         run(EIP_CMD_CUR_READ, a, 8'h00, 8'h01);
         check({got_nack, 8'(got.size())}, 9'h100);
      end
      sel <= pins;
      rd(EIP_CMD_CUR_READ, a, 12'h001, 8'h01);
      $display("test select done");
      wrap_up();
   end
endmodule
`default_nettype wire
